//--- swport_route.sv
// Per-port packet routing, acknowledge tracking and lane pairing
// Contract
// - Route checked packets by destination ID lookup
// - Drop bad-CRC packets, request retransmit
// - Forward received CRC unchanged
// - Hold sent packets until accepted symbol
// - Hop zero maintenance goes to registers
// - Nonzero hop: decrement, recompute CRC, forward
// - Only maintenance packets are ever altered
// - Bad control symbols: discard, send not-accepted
// - Destination and type match selects multicast
// - Eight multicast keys, each own port mask
// - Never copy back to arrival port
// - Copies go to all ports at once
// - Configurable multicast versus unicast egress arbitration
// - Sixteen ports form eight even/odd pairs
// - Even port four-lane or single, odd single
// - Four-lane even owns A-D, odd off-PHY
// - Single-lane even uses A, odd B
// - Order by priority and port congestion
// - Cut-through or store-and-forward, no head blocking; here a packet whose class slot is full waits in ST_PLACE, stalling intake
module swport_route #(
	parameter logic [swport_pkg::PORT_W-1:0] PORT_ID = 4'h0 // This port
) (
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	input wire logic RX_VALID,
	input wire logic [swport_pkg::DEST_W-1:0] RX_DEST,
	input wire logic [swport_pkg::TT_W-1:0] RX_TT,
	input wire logic [3:0] RX_FTYPE,
	input wire logic [1:0] RX_PRIO,
	input wire logic [7:0] RX_HOP,
	input wire logic [15:0] RX_CRC,
	input wire logic RX_CRC_OK,
	input wire logic RX_STORED,
	output logic RX_READY,
	input wire logic CS_VALID,
	input wire logic CS_CRC_OK,
	input wire logic CS_FIELDS_OK,
	input wire swport_pkg::cs_kind_t CS_KIND,
	input wire logic [swport_pkg::ACK_W-1:0] CS_ACKID,
	output logic PNA_SEND,
	output logic LINK_MAINT,
	output logic TX_RESEND,
	input wire logic TX_SENT,
	input wire logic [swport_pkg::ACK_W-1:0] TX_ACKID,
	output logic [swport_pkg::NACK-1:0] TX_OUTSTANDING,
	output logic MREQ_VALID,
	input wire logic MDONE,
	output logic MRESP_VALID,
	input wire logic FAB_UC_READY,
	input wire logic FAB_MC_READY,
	input wire logic [swport_pkg::NPORTS-1:0] CONGEST,
	output logic FAB_VALID,
	output logic FAB_MCAST,
	output logic [swport_pkg::NPORTS-1:0] FAB_MASK,
	output logic [1:0] FAB_PRIO,
	output logic [3:0] FAB_FTYPE,
	output logic [7:0] FAB_HOP,
	output logic [15:0] FAB_CRC,
	output logic [3:0] EVEN_LANE_EN,
	output logic [3:0] ODD_LANE_EN,
	output logic ODD_POWERED
);
	import swport_pkg::*;

	// One packet held for the fabric
	typedef struct packed {
		logic valid;
		logic mcast;
		logic [NPORTS-1:0] mask;
		logic [1:0] prio;
		logic [3:0] ftype;
		logic [7:0] hop;
		logic [15:0] crc;
	} slot_t;

	typedef enum {ST_IDLE, ST_LOOKUP, ST_PLACE, ST_MAINT} state_t;

	// All state of the port
	typedef struct packed {
		state_t st;
		logic [3:0] ctrl; // Store-and-forward, favour, 4x, odd down
		slot_t pend; // Packet under routing
		logic stored; // Payload fully buffered
		logic [DEST_W-1:0] dest;
		logic [TT_W-1:0] tt;
		slot_t uc; // Unicast slot toward the fabric
		slot_t mc; // Multicast slot toward the fabric
		logic [NACK-1:0] outst; // Sent, not yet accepted
		logic [15:0] crc_drops;
		logic [15:0] cs_drops;
		logic rx_ready;
		logic pna;
		logic link_maint;
		logic resend;
		logic mreq;
		logic mresp;
		slot_t fab; // Issued packet, valid one cycle
		logic [31:0] rdata;
		logic [3:0] even_lanes;
		logic [3:0] odd_lanes;
		logic odd_on;
	} port_t;

	port_t s_q; // Registered state
	port_t s_d; // Next state
	route_if rif (); // Link to the lookup tables
	logic rx_take; // Packet accepted this cycle
	logic cs_bad; // Control symbol fails a check
	logic uc_go; // Unicast slot may issue
	logic mc_go; // Multicast slot may issue
	logic pick_mc; // Arbiter chooses multicast
	logic mode4x; // Effective four-lane mode of the pair

	// Header CRC, recomputed only for forwarded maintenance packets
	function automatic logic [15:0] crc16(input logic [23:0] data);
		logic [15:0] c;
		c = CRC_SEED;
		for (int i = 23; i >= 0; i--) begin
			c = (c[15] ^ data[i]) ? ({c[14:0], 1'b0} ^ CRC_POLY)
				: {c[14:0], 1'b0};
		end
		return c;
	endfunction : crc16

	route_table u_table (
		.clk (CLOCK),
		.rst (RESET),
		.rif (rif.tbl)
	);

	// Table programming goes straight from the register port
	assign rif.lut_we = REG_WR && REG_ADDR == OFS_LUT;
	assign rif.lut_idx = REG_WDATA[LUT_IDX_LSB +: DEST_W];
	assign rif.lut_port = REG_WDATA[LUT_PORT_LSB +: PORT_W];
	assign rif.mc_we = REG_WR && REG_ADDR == OFS_MCAST;
	assign rif.mc_idx = REG_WDATA[MC_IDX_LSB +: GRP_W];
	assign rif.mc_valid = REG_WDATA[MC_VALID_BIT];
	assign rif.mc_tt = REG_WDATA[MC_TT_LSB +: TT_W];
	assign rif.mc_dest = REG_WDATA[MC_DEST_LSB +: DEST_W];
	assign rif.mc_mask = REG_WDATA[MC_MASK_LSB +: NPORTS];
	// Lookup request in the cycle after the packet is taken
	assign rif.req = s_q.st == ST_LOOKUP;
	assign rif.dest = s_q.dest;
	assign rif.tt = s_q.tt;

	assign rx_take = RX_VALID && s_q.rx_ready;
	assign cs_bad = CS_VALID && !(CS_CRC_OK && CS_FIELDS_OK);
	// An odd port can never run four lanes
	assign mode4x = s_q.ctrl[CTRL_MODE4X] && !PORT_ID[0];
	// Unicast waits on a congested target; multicast has its own path
	assign uc_go = s_q.uc.valid && FAB_UC_READY
		&& !(|(s_q.uc.mask & CONGEST));
	assign mc_go = s_q.mc.valid && FAB_MC_READY;
	// Higher priority first, the favour bit breaks a tie
	always_comb begin
		pick_mc = 1'b0;
		if (mc_go && !uc_go) begin
			pick_mc = 1'b1;
		end else if (mc_go && uc_go) begin
			if (s_q.mc.prio != s_q.uc.prio) begin
				pick_mc = s_q.mc.prio > s_q.uc.prio;
			end else begin
				pick_mc = s_q.ctrl[CTRL_MC_FAV];
			end
		end
	end

	// Next-state logic for the whole port
	always_comb begin
		s_d = s_q;
		s_d.pna = 1'b0;
		s_d.link_maint = 1'b0;
		s_d.resend = 1'b0;
		s_d.mreq = 1'b0;
		s_d.mresp = 1'b0;
		s_d.fab.valid = 1'b0;
		s_d.rdata = '0;
		s_d.stored = s_q.stored || RX_STORED;

		// Register writes and reads
		if (REG_WR && REG_ADDR == OFS_CTRL) begin
			s_d.ctrl = REG_WDATA[3:0];
		end
		if (REG_RD) begin
			case (REG_ADDR)
				OFS_CTRL: s_d.rdata = {28'h0000000, s_q.ctrl};
				OFS_STATUS: s_d.rdata = {s_q.cs_drops, s_q.crc_drops};
				OFS_OUTST: s_d.rdata = s_q.outst;
				default: s_d.rdata = '0; // Unmapped reads as zero
			endcase
		end

		// Packet intake and routing
		case (s_q.st)
			ST_IDLE: begin
				if (rx_take) begin
					s_d.rx_ready = 1'b0;
					if (!RX_CRC_OK) begin
						// Bad packet never enters the switch
						s_d.pna = 1'b1;
						s_d.crc_drops = s_q.crc_drops + CNT_STEP;
						s_d.st = ST_IDLE;
						s_d.rx_ready = 1'b1;
					end else begin
						s_d.pend.prio = RX_PRIO;
						s_d.pend.ftype = RX_FTYPE;
						s_d.pend.hop = RX_HOP;
						s_d.pend.crc = RX_CRC;
						s_d.dest = RX_DEST;
						s_d.tt = RX_TT;
						s_d.stored = RX_STORED;
						if (RX_FTYPE == FTYPE_MAINT && RX_HOP == HOP_LOCAL) begin
							s_d.mreq = 1'b1;
							s_d.st = ST_MAINT;
						end else begin
							if (RX_FTYPE == FTYPE_MAINT) begin
								// The one packet kind the switch rewrites
								s_d.pend.hop = RX_HOP - HOP_STEP;
								s_d.pend.crc = crc16({RX_DEST, RX_TT, RX_FTYPE,
									RX_PRIO, RX_HOP - HOP_STEP});
							end
							s_d.st = ST_LOOKUP;
						end
					end
				end
			end
			ST_LOOKUP: begin
				s_d.st = ST_PLACE;
			end
			ST_PLACE: begin
				s_d.pend.mcast = rif.mcast;
				if (rif.mcast) begin
					// Never reflect to the arrival port
					s_d.pend.mask = rif.mask & ~(NPORTS'(1) << PORT_ID);
				end else begin
					s_d.pend.mask = NPORTS'(1) << rif.port;
				end
				s_d.pend.valid = 1'b1;
				// Store-and-forward waits for the whole payload
				if (!s_q.ctrl[CTRL_SAF] || s_q.stored) begin
					// Each class has its own slot; a packet whose slot
					// is still full waits here and holds back both classes
					if (rif.mcast && !s_q.mc.valid) begin
						s_d.mc = s_d.pend;
						s_d.st = ST_IDLE;
						s_d.rx_ready = 1'b1;
					end else if (!rif.mcast && !s_q.uc.valid) begin
						s_d.uc = s_d.pend;
						s_d.st = ST_IDLE;
						s_d.rx_ready = 1'b1;
					end
				end
			end
			ST_MAINT: begin
				// Response is queued on this port once registers answer
				if (MDONE) begin
					s_d.mresp = 1'b1;
					s_d.st = ST_IDLE;
					s_d.rx_ready = 1'b1;
				end
			end
			default: begin
				s_d.st = ST_IDLE;
				s_d.rx_ready = 1'b1;
			end
		endcase

		// Issue to the fabric; a multicast mask leaves in one transfer
		if (pick_mc) begin
			s_d.fab = s_q.mc;
			s_d.mc.valid = 1'b0;
		end else if (uc_go) begin
			s_d.fab = s_q.uc;
			s_d.uc.valid = 1'b0;
		end

		// Control symbols: only checked ones act on the port
		if (cs_bad) begin
			s_d.pna = 1'b1;
			s_d.cs_drops = s_q.cs_drops + CNT_STEP;
		end else if (CS_VALID) begin
			case (CS_KIND)
				CS_ACCEPT: s_d.outst[CS_ACKID] = 1'b0;
				CS_NOT_ACCEPT: s_d.resend = 1'b1;
				CS_LINK: s_d.link_maint = 1'b1;
				default: s_d.link_maint = 1'b0;
			endcase
		end
		// A send in the same cycle as an accept keeps its hold
		if (TX_SENT) begin
			s_d.outst[TX_ACKID] = 1'b1;
		end

		// Lane pairing; odd power only touches the odd side
		if (mode4x) begin
			s_d.even_lanes = LANES_ALL;
			s_d.odd_lanes = LANES_NONE;
		end else begin
			s_d.even_lanes = LANE_A;
			s_d.odd_lanes = s_q.ctrl[CTRL_ODD_PD] ? LANES_NONE
				: LANE_B;
		end
		s_d.odd_on = !s_q.ctrl[CTRL_ODD_PD];
	end

	// State register
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.ctrl <= CTRL_RESET;
			s_q.rx_ready <= 1'b1;
			s_q.even_lanes <= LANE_A;
			s_q.odd_lanes <= LANE_B;
			s_q.odd_on <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Every output straight from the state register
	assign REG_RDATA = s_q.rdata;
	assign RX_READY = s_q.rx_ready;
	assign PNA_SEND = s_q.pna;
	assign LINK_MAINT = s_q.link_maint;
	assign TX_RESEND = s_q.resend;
	assign TX_OUTSTANDING = s_q.outst;
	assign MREQ_VALID = s_q.mreq;
	assign MRESP_VALID = s_q.mresp;
	assign FAB_VALID = s_q.fab.valid;
	assign FAB_MCAST = s_q.fab.mcast;
	assign FAB_MASK = s_q.fab.mask;
	assign FAB_PRIO = s_q.fab.prio;
	assign FAB_FTYPE = s_q.fab.ftype;
	assign FAB_HOP = s_q.fab.hop;
	assign FAB_CRC = s_q.fab.crc;
	assign EVEN_LANE_EN = s_q.even_lanes;
	assign ODD_LANE_EN = s_q.odd_lanes;
	assign ODD_POWERED = s_q.odd_on;

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RESET);

	crc_drop_a: assert property (rx_take && !RX_CRC_OK && s_q.st == ST_IDLE
		|=> PNA_SEND && s_q.st == ST_IDLE)
		else $error("bad packet not dropped with not-accepted");
	symbol_reject_a: assert property (cs_bad |=> PNA_SEND && $changed(s_q.cs_drops))
		else $error("bad control symbol not rejected");
	no_reflect_a: assert property (FAB_VALID && FAB_MCAST |-> !FAB_MASK[PORT_ID])
		else $error("multicast copy sent to arrival port");
	crc_keep_a: assert property (rx_take && RX_CRC_OK && RX_FTYPE != FTYPE_MAINT
		|=> s_q.pend.crc == $past(RX_CRC) && s_q.pend.hop == $past(RX_HOP))
		else $error("non-maintenance packet altered");
	hop_step_a: assert property (rx_take && RX_CRC_OK && RX_FTYPE == FTYPE_MAINT
		&& RX_HOP != HOP_LOCAL |=> s_q.pend.hop == $past(RX_HOP) - HOP_STEP)
		else $error("forwarded maintenance hop count not decremented");
	local_maint_a: assert property (rx_take && RX_CRC_OK && RX_FTYPE == FTYPE_MAINT
		&& RX_HOP == HOP_LOCAL |=> MREQ_VALID ##1 !MREQ_VALID)
		else $error("local maintenance not passed to registers");
	ack_hold_a: assert property (TX_SENT |=> TX_OUTSTANDING[$past(TX_ACKID)])
		else $error("sent packet not held for acknowledge");
	mc_favour_a: assert property (mc_go && uc_go && s_q.mc.prio == s_q.uc.prio
		|=> FAB_VALID && FAB_MCAST == $past(s_q.ctrl[CTRL_MC_FAV]))
		else $error("tie not broken by multicast favour");
	lane_4x_a: assert property (mode4x |=> EVEN_LANE_EN == LANES_ALL
		&& ODD_LANE_EN == LANES_NONE)
		else $error("four-lane pair lane ownership wrong");
	odd_pd_a: assert property ($changed(s_q.ctrl[CTRL_ODD_PD])
		&& $stable(s_q.ctrl[CTRL_MODE4X]) |=> $stable(EVEN_LANE_EN))
		else $error("odd power-down disturbed even port lanes");
endmodule : swport_route

//--- swport_pkg.sv
// Shared constants and types for the switch port routing block
package swport_pkg;
	localparam int DEST_W = 8; // Destination ID width
	localparam int NPORTS = 16; // Ports on the switch
	localparam int PORT_W = 4; // Port number width
	localparam int NGROUPS = 8; // Multicast key and group entries
	localparam int GRP_W = 3; // Multicast entry index width
	localparam int TT_W = 2; // Transport type field width
	localparam int ACK_W = 5; // Packet acknowledge ID width
	localparam int NACK = 32; // Acknowledge IDs in flight
	localparam logic [3:0] FTYPE_MAINT = 4'h8; // Maintenance format type
	localparam logic [7:0] HOP_LOCAL = 8'h00; // Hop count aimed at this switch
	localparam logic [7:0] HOP_STEP = 8'h01; // Hop count decrement
	localparam logic [15:0] CRC_SEED = 16'hFFFF; // CRC start value
	localparam logic [15:0] CRC_POLY = 16'h1021; // CRC polynomial
	localparam logic [15:0] CNT_STEP = 16'h0001; // Error counter step
	// Register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_LUT = 8'h08;
	localparam logic [7:0] OFS_MCAST = 8'h0C;
	localparam logic [7:0] OFS_OUTST = 8'h10;
	// Control register bit positions and value after reset
	localparam int CTRL_SAF = 0;
	localparam int CTRL_MC_FAV = 1;
	localparam int CTRL_MODE4X = 2;
	localparam int CTRL_ODD_PD = 3;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	// Lookup table write fields
	localparam int LUT_PORT_LSB = 0;
	localparam int LUT_IDX_LSB = 8;
	// Multicast entry write fields
	localparam int MC_MASK_LSB = 0;
	localparam int MC_DEST_LSB = 16;
	localparam int MC_TT_LSB = 24;
	localparam int MC_VALID_BIT = 26;
	localparam int MC_IDX_LSB = 27;
	// Lane enables for a pair: lane A is bit 0 up to lane D at bit 3
	localparam logic [3:0] LANES_ALL = 4'hF;
	localparam logic [3:0] LANE_A = 4'h1;
	localparam logic [3:0] LANE_B = 4'h2;
	localparam logic [3:0] LANES_NONE = 4'h0;
	// Control symbol kinds as decoded by the receiver
	typedef enum logic [1:0] {
		CS_ACCEPT = 2'h0,
		CS_NOT_ACCEPT = 2'h1,
		CS_LINK = 2'h2,
		CS_OTHER = 2'h3
	} cs_kind_t;
endpackage : swport_pkg

//--- route_if.sv
// Lookup request and table programming signals between core and table
interface route_if;
	import swport_pkg::*;
	logic req; // Lookup request, one cycle
	logic [DEST_W-1:0] dest; // Destination ID to look up
	logic [TT_W-1:0] tt; // Transport type of the packet
	logic rsp; // Lookup answer, one cycle after req
	logic [PORT_W-1:0] port; // Unicast egress port
	logic mcast; // Multicast key matched
	logic [NPORTS-1:0] mask; // Multicast group mask
	logic lut_we; // Lookup table write
	logic [DEST_W-1:0] lut_idx;
	logic [PORT_W-1:0] lut_port;
	logic mc_we; // Multicast entry write
	logic [GRP_W-1:0] mc_idx;
	logic mc_valid;
	logic [TT_W-1:0] mc_tt;
	logic [DEST_W-1:0] mc_dest;
	logic [NPORTS-1:0] mc_mask;
	modport core (output req, dest, tt, lut_we, lut_idx, lut_port, mc_we,
		mc_idx, mc_valid, mc_tt, mc_dest, mc_mask,
		input rsp, port, mcast, mask);
	modport tbl (input req, dest, tt, lut_we, lut_idx, lut_port, mc_we,
		mc_idx, mc_valid, mc_tt, mc_dest, mc_mask,
		output rsp, port, mcast, mask);
endinterface : route_if

//--- route_table.sv
// Unicast lookup table and multicast key table of one ingress port
module route_table (
	input wire logic clk,
	input wire logic rst,
	route_if.tbl rif
);
	import swport_pkg::*;

	// Whole table state; the port, mcast and mask answers hold until the next lookup
	typedef struct packed {
		logic [(1<<DEST_W)-1:0][PORT_W-1:0] lut;
		logic [NGROUPS-1:0] mc_valid;
		logic [NGROUPS-1:0][TT_W-1:0] mc_tt;
		logic [NGROUPS-1:0][DEST_W-1:0] mc_dest;
		logic [NGROUPS-1:0][NPORTS-1:0] mc_mask;
		logic rsp;
		logic [PORT_W-1:0] port;
		logic mcast;
		logic [NPORTS-1:0] mask;
	} tbl_t;

	tbl_t s_q; // Registered table
	tbl_t s_d; // Next table
	logic [NGROUPS-1:0] hit; // Key match per entry

	// Key compare on destination ID and transport type, per entry
	for (genvar g = 0; g < NGROUPS; g++) begin : g_key
		assign hit[g] = s_q.mc_valid[g] && s_q.mc_dest[g] == rif.dest
			&& s_q.mc_tt[g] == rif.tt;
	end

	// Lookup and table writes
	always_comb begin
		s_d = s_q;
		s_d.rsp = rif.req;
		if (rif.req) begin
			s_d.port = s_q.lut[rif.dest];
			s_d.mcast = |hit;
			s_d.mask = '0;
			// Lowest matching entry wins if software keys two alike
			for (int g = NGROUPS - 1; g >= 0; g--) begin
				if (hit[g]) begin
					s_d.mask = s_q.mc_mask[g];
				end
			end
		end
		if (rif.lut_we) begin
			s_d.lut[rif.lut_idx] = rif.lut_port;
		end
		if (rif.mc_we) begin
			s_d.mc_valid[rif.mc_idx] = rif.mc_valid;
			s_d.mc_tt[rif.mc_idx] = rif.mc_tt;
			s_d.mc_dest[rif.mc_idx] = rif.mc_dest;
			s_d.mc_mask[rif.mc_idx] = rif.mc_mask;
		end
	end

	// State register; empty table sends everything to port 0
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rif.rsp = s_q.rsp;
	assign rif.port = s_q.port;
	assign rif.mcast = s_q.mcast;
	assign rif.mask = s_q.mask;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	lookup_answer_a: assert property (rif.req |=> rif.rsp && !$past(rif.rsp))
		else $error("lookup answer not one cycle after request");
	mcast_steer_a: assert property (rif.req && (|hit) |=> rif.mcast)
		else $error("multicast key match not flagged");
endmodule : route_table

//--- link_peer.sv
// Far end of the link: accepts sent packets and sends commanded symbols
module link_peer
	import swport_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic tx_sent,
	input wire logic [ACK_W-1:0] tx_ackid,
	input wire logic [7:0] delay, // Cycles before a packet is accepted
	input wire logic cmd_valid, // Send one commanded symbol
	input wire cs_kind_t cmd_kind,
	input wire logic cmd_bad, // Spoil the commanded symbol CRC
	output logic cs_valid = 1'b0,
	output logic cs_crc_ok = 1'b0,
	output logic cs_fields_ok = 1'b0,
	output cs_kind_t cs_kind = CS_OTHER,
	output logic [ACK_W-1:0] cs_ackid = '0
);
	logic [ACK_W-1:0] ids[$]; // Sent packets not yet accepted
	int due[$]; // Cycle at which each one is accepted
	int now = 0; // Free-running cycle count
	// One symbol per cycle at most; commands go first, acceptances wait
	always @(posedge clk) begin
		now <= now + 1;
		cs_valid <= 1'b0;
		// Idle fields wander so a stale symbol is never mistaken for a new one
		cs_ackid <= ~cs_ackid;
		cs_kind <= cs_kind_t'(~cs_kind);
		cs_crc_ok <= ~cs_crc_ok;
		cs_fields_ok <= ~cs_fields_ok;
		if (rst) begin
			ids.delete();
			due.delete();
		end else begin
			if (tx_sent) begin
				ids.push_back(tx_ackid);
				due.push_back(now + delay);
			end
			if (cmd_valid) begin
				cs_valid <= 1'b1;
				cs_kind <= cmd_kind;
				cs_crc_ok <= ~cmd_bad;
				cs_fields_ok <= 1'b1;
			end else if (ids.size() > 0 && due[0] <= now) begin
				cs_valid <= 1'b1;
				cs_kind <= CS_ACCEPT;
				cs_crc_ok <= 1'b1;
				cs_fields_ok <= 1'b1;
				cs_ackid <= ids.pop_front();
				void'(due.pop_front());
			end
		end
	end
endmodule : link_peer

//--- serial_switch_port_routing_tb.sv
// Self-checking bench for the per-port routing block
module serial_switch_port_routing_tb
	import swport_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLOCK = 1'b0, RESET = 1'b1;
	logic [7:0] REG_ADDR = 8'h00;
	logic [31:0] REG_WDATA = 32'h0, REG_RDATA, TX_OUTSTANDING, r;
	logic REG_WR = 1'b0, REG_RD = 1'b0, RX_VALID = 1'b0, RX_READY;
	logic [7:0] RX_DEST = 8'h00, RX_HOP = 8'h00, FAB_HOP, peer_delay = 8'h01;
	logic [1:0] RX_TT = 2'h0, RX_PRIO = 2'h0, FAB_PRIO;
	logic [3:0] RX_FTYPE = 4'h0, FAB_FTYPE, EVEN_LANE_EN, ODD_LANE_EN;
	logic [15:0] RX_CRC = 16'h0, FAB_CRC, FAB_MASK, CONGEST = 16'h0;
	logic RX_CRC_OK = 1'b1, RX_STORED = 1'b0, TX_SENT = 1'b0, MDONE = 1'b0;
	logic CS_VALID, CS_CRC_OK, CS_FIELDS_OK, PNA_SEND, LINK_MAINT, TX_RESEND;
	logic MREQ_VALID, MRESP_VALID, FAB_VALID, FAB_MCAST, ODD_POWERED;
	logic FAB_UC_READY = 1'b1, FAB_MC_READY = 1'b1; // Fabric ready except while the favour test stalls both classes
	logic [4:0] CS_ACKID, TX_ACKID = 5'h00, seen; // seen: fab,pna,link,resend,mreq
	logic cmd_valid = 1'b0, cmd_bad = 1'b0;
	cs_kind_t CS_KIND, cmd_kind = CS_ACCEPT;
	int fails = 0, checks = 0;
	swport_route #(.PORT_ID(4'h0)) DUT (.CLOCK(CLOCK), .RESET(RESET),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
		.REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .RX_VALID(RX_VALID),
		.RX_DEST(RX_DEST), .RX_TT(RX_TT), .RX_FTYPE(RX_FTYPE), .RX_PRIO(RX_PRIO),
		.RX_HOP(RX_HOP), .RX_CRC(RX_CRC), .RX_CRC_OK(RX_CRC_OK),
		.RX_STORED(RX_STORED), .RX_READY(RX_READY), .CS_VALID(CS_VALID),
		.CS_CRC_OK(CS_CRC_OK), .CS_FIELDS_OK(CS_FIELDS_OK), .CS_KIND(CS_KIND),
		.CS_ACKID(CS_ACKID), .PNA_SEND(PNA_SEND), .LINK_MAINT(LINK_MAINT),
		.TX_RESEND(TX_RESEND), .TX_SENT(TX_SENT), .TX_ACKID(TX_ACKID),
		.TX_OUTSTANDING(TX_OUTSTANDING), .MREQ_VALID(MREQ_VALID),
		.MDONE(MDONE), .MRESP_VALID(MRESP_VALID), .FAB_UC_READY(FAB_UC_READY),
		.FAB_MC_READY(FAB_MC_READY), .CONGEST(CONGEST), .FAB_VALID(FAB_VALID),
		.FAB_MCAST(FAB_MCAST), .FAB_MASK(FAB_MASK), .FAB_PRIO(FAB_PRIO),
		.FAB_FTYPE(FAB_FTYPE), .FAB_HOP(FAB_HOP), .FAB_CRC(FAB_CRC),
		.EVEN_LANE_EN(EVEN_LANE_EN), .ODD_LANE_EN(ODD_LANE_EN),
		.ODD_POWERED(ODD_POWERED));
	link_peer peer (.clk(CLOCK), .rst(RESET), .tx_sent(TX_SENT),
		.tx_ackid(TX_ACKID), .delay(peer_delay), .cmd_valid(cmd_valid),
		.cmd_kind(cmd_kind), .cmd_bad(cmd_bad), .cs_valid(CS_VALID),
		.cs_crc_ok(CS_CRC_OK), .cs_fields_ok(CS_FIELDS_OK), .cs_kind(CS_KIND),
		.cs_ackid(CS_ACKID));
	// 20 MHz clock
	always #25 CLOCK = ~CLOCK;
	// Closing report, the single exit of the run
	task stop_test;
		$display("Checks %0d, mismatches %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test
	// Four-state compare, so an unknown never matches
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One-cycle register write
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CLOCK);
		REG_WR <= 1'b0;
	endtask : wr
	// One-cycle register read; data stand only in the following cycle
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge CLOCK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CLOCK);
		REG_RD <= 1'b0;
		#1 d = REG_RDATA;
	endtask : rd
	// Gather one-cycle pulses over n cycles
	task watch(input int n);
		seen = 5'h00;
		repeat (n) begin
			#1 seen |= {FAB_VALID, PNA_SEND, LINK_MAINT, TX_RESEND, MREQ_VALID};
			@(posedge CLOCK);
		end
	endtask : watch
	// Offer one descriptor once the port is ready; ends at the taking edge
	task pkt(input logic [7:0] dest, input logic [1:0] tt,
		input logic [3:0] ft, input logic [7:0] hop, input logic ok);
		int n;
		#1;
		for (n = 0; RX_READY !== 1'b1; n++) begin
			if (n == 40) begin
				fails++;
				stop_test;
			end
			@(posedge CLOCK);
			#1;
		end
		@(posedge CLOCK);
		RX_VALID <= 1'b1;
		RX_DEST <= dest;
		RX_TT <= tt;
		RX_FTYPE <= ft;
		RX_HOP <= hop;
		RX_CRC <= 16'hABCD;
		RX_CRC_OK <= ok;
		RX_PRIO <= 2'h2;
		@(posedge CLOCK);
		RX_VALID <= 1'b0;
	endtask : pkt
	// Expect one fabric issue with the given fields
	task fab(input logic mc, input logic [15:0] mask, input logic [7:0] hop,
		input logic [15:0] crc);
		watch(10);
		chk(seen[4], 1'b1);
		chk(FAB_MCAST, mc);
		chk(FAB_MASK, mask);
		chk(FAB_HOP, hop);
		chk(FAB_CRC, crc);
		chk(FAB_PRIO, 2'h2);
		chk(FAB_FTYPE, RX_FTYPE);
	endtask : fab
	// Have the far end send one symbol, then watch the answers
	task sym(input cs_kind_t k, input logic bad);
		@(posedge CLOCK);
		cmd_valid <= 1'b1;
		cmd_kind <= k;
		cmd_bad <= bad;
		@(posedge CLOCK);
		cmd_valid <= 1'b0;
		watch(4);
	endtask : sym
	// Reference CRC, MSB first, of a rebuilt maintenance header
	function automatic logic [15:0] crc16(input logic [23:0] d);
		logic [15:0] c;
		c = CRC_SEED;
		for (int i = 23; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
		return c;
	endfunction : crc16
	// Hang guard
	initial begin
		repeat (20000) @(posedge CLOCK);
		fails++;
		stop_test;
	end
	// Main sequence
	initial begin
		repeat (2) @(posedge CLOCK);
		RESET <= 1'b0;
		#1 chk({RX_READY, ODD_POWERED, EVEN_LANE_EN, ODD_LANE_EN}, 10'h312);
		chk(TX_OUTSTANDING, 32'h0);
		rd(OFS_CTRL, r);
		chk(r, 32'h0);
		rd(8'h20, r); // Unmapped place reads zero
		chk(r, 32'h0);
		rd(OFS_LUT, r); // Write-only place reads zero
		chk(r, 32'h0);
		wr(OFS_CTRL, 32'h4);
		rd(OFS_CTRL, r);
		chk(r, 32'h4);
		chk({ODD_POWERED, EVEN_LANE_EN, ODD_LANE_EN}, {1'b1, LANES_ALL, LANES_NONE});
		wr(OFS_CTRL, 32'hC);
		rd(OFS_CTRL, r);
		chk({ODD_POWERED, EVEN_LANE_EN}, {1'b0, LANES_ALL});
		wr(OFS_CTRL, 32'h0);
		rd(OFS_CTRL, r);
		chk({EVEN_LANE_EN, ODD_LANE_EN}, {LANE_A, LANE_B});
		wr(OFS_LUT, 32'h0000_2205);
		pkt(8'h22, 2'h0, 4'h5, 8'h00, 1'b1);
		fab(1'b0, 16'h0020, 8'h00, 16'hABCD);
		// Congested target holds the packet back
		@(posedge CLOCK) CONGEST <= 16'h0020;
		pkt(8'h22, 2'h0, 4'h5, 8'h00, 1'b1);
		watch(10);
		chk(seen[4], 1'b0);
		@(posedge CLOCK) CONGEST <= 16'h0000;
		fab(1'b0, 16'h0020, 8'h00, 16'hABCD);
		// Store-and-forward waits for the whole payload
		wr(OFS_CTRL, 32'h1);
		pkt(8'h22, 2'h0, 4'h5, 8'h00, 1'b1);
		watch(10);
		chk(seen[4], 1'b0);
		@(posedge CLOCK) RX_STORED <= 1'b1;
		@(posedge CLOCK) RX_STORED <= 1'b0;
		fab(1'b0, 16'h0020, 8'h00, 16'hABCD);
		wr(OFS_CTRL, 32'h0);
		pkt(8'h22, 2'h0, 4'h5, 8'h00, 1'b0);
		watch(8);
		chk(seen[4:3], 2'b01);
		// All eight keys, each mask holding the arrival port too
		for (int i = 0; i < 8; i++)
			wr(OFS_MCAST, {2'b00, i[2:0], 1'b1, 2'h1, 8'h40 + i[7:0],
				(16'h0100 << i) | 16'h0001});
		for (int i = 0; i < 8; i++) begin
			pkt(8'h40 + i[7:0], 2'h1, 4'h5, 8'h5A, 1'b1);
			fab(1'b1, 16'h0100 << i, 8'h5A, 16'hABCD);
		end
		// Both classes stalled at one priority; the favour bit picks first
		wr(OFS_CTRL, 32'h2);
		FAB_UC_READY <= 1'b0;
		FAB_MC_READY <= 1'b0;
		pkt(8'h41, 2'h1, 4'h5, 8'h5A, 1'b1);
		pkt(8'h22, 2'h0, 4'h5, 8'h5A, 1'b1);
		watch(4);
		chk(seen[4], 1'b0);
		FAB_UC_READY <= 1'b1;
		FAB_MC_READY <= 1'b1;
		@(posedge CLOCK);
		#1 chk({FAB_VALID, FAB_MCAST, FAB_MASK}, {2'b11, 16'h0200});
		@(posedge CLOCK);
		#1 chk({FAB_VALID, FAB_MCAST, FAB_MASK}, {2'b10, 16'h0020});
		pkt(8'h40, 2'h2, 4'h5, 8'h5A, 1'b1);
		fab(1'b0, 16'h0001, 8'h5A, 16'hABCD);
		pkt(8'h22, 2'h0, FTYPE_MAINT, 8'h03, 1'b1);
		fab(1'b0, 16'h0020, 8'h02, crc16({8'h22, 2'h0, FTYPE_MAINT, 2'h2, 8'h02}));
		pkt(8'h22, 2'h0, FTYPE_MAINT, HOP_LOCAL, 1'b1);
		watch(4);
		chk({seen[4], seen[0]}, 2'b01);
		@(posedge CLOCK) MDONE <= 1'b1;
		@(posedge CLOCK) MDONE <= 1'b0;
		#1 chk(MRESP_VALID, 1'b1);
		sym(CS_ACCEPT, 1'b1);
		chk(seen[3], 1'b1);
		sym(CS_LINK, 1'b0);
		chk(seen[3:1], 3'b010);
		sym(CS_NOT_ACCEPT, 1'b0);
		chk(seen[3:1], 3'b001);
		// Slow far end: the sent packet stays held until accepted
		@(posedge CLOCK);
		peer_delay <= 8'd20;
		TX_SENT <= 1'b1;
		TX_ACKID <= 5'd3;
		@(posedge CLOCK) TX_SENT <= 1'b0;
		repeat (10) @(posedge CLOCK);
		#1 chk(TX_OUTSTANDING, 32'h8);
		repeat (15) @(posedge CLOCK);
		#1 chk(TX_OUTSTANDING, 32'h0);
		rd(OFS_STATUS, r);
		chk(r, 32'h0001_0001);
		stop_test;
	end
endmodule : serial_switch_port_routing_tb
